// file: rtl/phy_regs_pkg.sv
// How it works
// - identifier low bits 15:10 show six fixed organisation identifier bits
// - identifier low bits 9:4 hold a fixed read-only model number
// - identifier low bits 3:0 hold a fixed read-only revision number
// - advertisement bit 15, next page flag, writable, resets to 0
// - advertisement bit 13 sends remote fault in the transmitted code word
// - advertisement bit 13 reads back last write, 0 after reset
// - advertisement bit 10, pause flag, writable, resets to 1, advertised only
// - advertisement bits 9:5 each advertise or suppress one ability
// - reset sets bits 8:5 and clears bit 9 of the advertisement
// - advertisement bits 9:5 read back last written values or defaults
// - advertisement bits 4:0 always read as selector 00001
// - partner bit 15 shows partner next page support
// - partner bit 14 set once partner code word is received
// - partner bit 13 mirrors partner remote fault, no action taken
// - partner bit 10 shows partner pause capability
// - partner bits 4:0 hold partner selector, cleared on restart or reset
// - partner bits 9:5 show partner abilities, cleared on restart or reset
// - control bit 9 write of 1 restarts negotiation if enabled, reads 0
// - status bit 5 reads 1 only after negotiation completes
`default_nettype none
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS    = 5'h00;
  localparam logic [4:0] STAT_OFS    = 5'h01;
  localparam logic [4:0] ID_HI_OFS   = 5'h02;
  localparam logic [4:0] ID_LO_OFS   = 5'h03;
  localparam logic [4:0] ADV_OFS     = 5'h04;
  localparam logic [4:0] PARTNER_OFS = 5'h05;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_AN_EN_BIT     = 12;
  localparam int CTRL_RESTART_BIT   = 9;
  localparam int STAT_AN_DONE_BIT   = 5;
  localparam int ADV_NEXT_PAGE_BIT  = 15;
  localparam int ADV_FAULT_BIT      = 13;
  localparam int ADV_PAUSE_BIT      = 10;
  localparam int PARTNER_ACK_BIT    = 14;
  localparam logic        CTRL_AN_EN_RST = 1'b1;
  // writable bits of the advertisement: 15, 13, 10, 9:5
  localparam logic [15:0] ADV_WR_MASK    = 16'ha7e0;
  localparam logic [15:0] ADV_RST        = 16'h05e0;
  localparam logic [4:0]  ADV_SELECTOR   = 5'h01;
  // partner bits copied from the code word: 15, 13, 10, 9:0
  localparam logic [15:0] PARTNER_COPY_MASK = 16'ha7ff;
  localparam logic [15:0] PARTNER_RST       = 16'h0000;

  // ----------------------------------------------------------------
  // identification, values are arbitrary
  // ----------------------------------------------------------------
  localparam logic [15:0] ID_HI_VAL  = 16'h0a5a;
  localparam logic [5:0]  OUI_LOW    = 6'h15;
  localparam logic [5:0]  MODEL_NUM  = 6'h2a;
  localparam logic [3:0]  REVISION   = 4'h3;

  // ----------------------------------------------------------------
  // management frame
  // ----------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] PHY_ADDR      = 5'h01;

endpackage
`default_nettype wire

// file: rtl/autoneg_ability_id_registers.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_id_registers
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output var  logic        mdio_o,
  output var  logic        mdio_oe_n_o,
  // negotiation engine
  input  wire logic [15:0] partner_word_i,
  input  wire logic        partner_word_valid_i,
  input  wire logic        an_complete_i,
  output var  logic [15:0] adv_word_o,
  output var  logic        an_restart_o,
  output var  logic        an_enable_o
);

  typedef enum logic [2:0] {PRE, START, OPC, ADDR, TURN, DATA} frame_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] mdc_sy_ff;
  logic [2:0] mdio_sy_ff;
  logic       mdc_lv_ff;
  logic       mdio_lv_ff;
  logic       nxt_mdc_lv;
  logic       nxt_mdio_lv;
  logic       rise_c;

  always_comb
  begin
    nxt_mdc_lv  = (mdc_sy_ff[1] == mdc_sy_ff[2]) ? mdc_sy_ff[2] : mdc_lv_ff;
    nxt_mdio_lv = (mdio_sy_ff[1] == mdio_sy_ff[2]) ? mdio_sy_ff[2] : mdio_lv_ff;
    rise_c      = nxt_mdc_lv && !mdc_lv_ff;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mdc_sy_ff  <= 3'h0;
      mdio_sy_ff <= 3'h7;
      mdc_lv_ff  <= 1'b0;
      mdio_lv_ff <= 1'b1;
    end
    else
    begin
      mdc_sy_ff  <= {mdc_sy_ff[1:0], mdc_i};
      mdio_sy_ff <= {mdio_sy_ff[1:0], mdio_i};
      mdc_lv_ff  <= nxt_mdc_lv;
      mdio_lv_ff <= nxt_mdio_lv;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] adv_ff;
  logic [15:0] partner_ff;
  logic        an_en_ff;
  logic        restart_ff;
  logic [15:0] adv_out_ff;
  logic [15:0] nxt_adv;
  logic [15:0] nxt_partner;
  logic [15:0] nxt_adv_out;
  logic        nxt_an_en;
  logic        nxt_restart;
  logic        wr_c;
  logic [15:0] wr_data_c;
  logic [4:0]  regad_ff;

  // what software reads at each offset; unmapped offsets read zero
  function automatic logic [15:0] reg_read(input logic [4:0] ofs,
                                           input logic [15:0] adv,
                                           input logic [15:0] lp,
                                           input logic        en,
                                           input logic        done);
    logic [15:0] r;
    r = 16'h0000;
    unique case (ofs)
      phy_regs_pkg::CTRL_OFS:    r[phy_regs_pkg::CTRL_AN_EN_BIT] = en;
      phy_regs_pkg::STAT_OFS:    r[phy_regs_pkg::STAT_AN_DONE_BIT] = done;
      phy_regs_pkg::ID_HI_OFS:   r = phy_regs_pkg::ID_HI_VAL;
      phy_regs_pkg::ID_LO_OFS:   r = {phy_regs_pkg::OUI_LOW, phy_regs_pkg::MODEL_NUM,
                                      phy_regs_pkg::REVISION};
      phy_regs_pkg::ADV_OFS:     r = (adv & phy_regs_pkg::ADV_WR_MASK)
                                     | {11'h000, phy_regs_pkg::ADV_SELECTOR};
      phy_regs_pkg::PARTNER_OFS: r = lp;
      default:                   r = 16'h0000;
    endcase
    return r;
  endfunction

  always_comb
  begin
    nxt_adv     = adv_ff;
    nxt_an_en   = an_en_ff;
    nxt_restart = 1'b0;
    nxt_partner = partner_ff;
    if (wr_c && regad_ff == phy_regs_pkg::ADV_OFS)
      // only the writable bits take the value; the rest stay fixed
      nxt_adv = wr_data_c & phy_regs_pkg::ADV_WR_MASK;
    if (wr_c && regad_ff == phy_regs_pkg::CTRL_OFS)
    begin
      nxt_an_en   = wr_data_c[phy_regs_pkg::CTRL_AN_EN_BIT];
      // restart is a one-cycle pulse, so the bit never reads back as 1
      nxt_restart = wr_data_c[phy_regs_pkg::CTRL_RESTART_BIT]
                    && wr_data_c[phy_regs_pkg::CTRL_AN_EN_BIT];
    end
    if (restart_ff)
      nxt_partner = phy_regs_pkg::PARTNER_RST;
    // a word arriving with the restart is kept: the set wins
    if (partner_word_valid_i)
    begin
      nxt_partner = partner_word_i & phy_regs_pkg::PARTNER_COPY_MASK;
      nxt_partner[phy_regs_pkg::PARTNER_ACK_BIT] = 1'b1;
    end
    // the engine sends exactly what software reads back
    nxt_adv_out = reg_read(phy_regs_pkg::ADV_OFS, nxt_adv, nxt_partner,
                           nxt_an_en, 1'b0);
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      adv_ff     <= phy_regs_pkg::ADV_RST;
      partner_ff <= phy_regs_pkg::PARTNER_RST;
      an_en_ff   <= phy_regs_pkg::CTRL_AN_EN_RST;
      restart_ff <= 1'b0;
      adv_out_ff <= phy_regs_pkg::ADV_RST | {11'h000, phy_regs_pkg::ADV_SELECTOR};
    end
    else
    begin
      adv_ff     <= nxt_adv;
      partner_ff <= nxt_partner;
      an_en_ff   <= nxt_an_en;
      restart_ff <= nxt_restart;
      adv_out_ff <= nxt_adv_out;
    end
  end

  assign adv_word_o   = adv_out_ff;
  assign an_restart_o = restart_ff;
  assign an_enable_o  = an_en_ff;

  // ----------------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------------
  frame_t      st_ff;
  frame_t      nxt_st;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic        rd_op_ff;
  logic        nxt_rd_op;
  logic        hit_ff;
  logic        nxt_hit;
  logic [4:0]  nxt_regad;
  logic        mdio_ff;
  logic        nxt_mdio;
  logic        oe_n_ff;
  logic        nxt_oe_n;
  logic [9:0]  addr_c;
  logic [15:0] rd_c;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_rd_op = rd_op_ff;
    nxt_hit   = hit_ff;
    nxt_regad = regad_ff;
    nxt_mdio  = mdio_ff;
    nxt_oe_n  = oe_n_ff;
    wr_c      = 1'b0;
    wr_data_c = {sh_ff[14:0], nxt_mdio_lv};
    addr_c    = {sh_ff[8:0], nxt_mdio_lv};
    rd_c      = reg_read(regad_ff, adv_ff, partner_ff, an_en_ff, an_complete_i);
    if (rise_c)
    begin
      unique case (st_ff)
        PRE:
        begin
          if (nxt_mdio_lv)
            nxt_cnt = (cnt_ff == phy_regs_pkg::PREAMBLE_ONES) ? cnt_ff : cnt_ff + 6'h01;
          else if (cnt_ff == phy_regs_pkg::PREAMBLE_ONES)
            nxt_st = START;
          else
            nxt_cnt = 6'h00;
        end
        START:
        begin
          nxt_cnt = 6'h00;
          nxt_st  = nxt_mdio_lv ? OPC : PRE;
        end
        OPC:
        begin
          nxt_sh  = {sh_ff[14:0], nxt_mdio_lv};
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h01)
          begin
            nxt_cnt   = 6'h00;
            nxt_rd_op = ({sh_ff[0], nxt_mdio_lv} == 2'b10);
            nxt_st    = (sh_ff[0] != nxt_mdio_lv) ? ADDR : PRE;
          end
        end
        ADDR:
        begin
          nxt_sh  = {sh_ff[14:0], nxt_mdio_lv};
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h09)
          begin
            nxt_cnt   = 6'h00;
            nxt_hit   = (addr_c[9:5] == phy_regs_pkg::PHY_ADDR);
            nxt_regad = addr_c[4:0];
            nxt_st    = TURN;
          end
        end
        TURN:
        begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00 && hit_ff && rd_op_ff)
          begin
            nxt_mdio = 1'b0;
            nxt_oe_n = 1'b0;
          end
          if (cnt_ff == 6'h01)
          begin
            nxt_cnt  = 6'h00;
            nxt_st   = DATA;
            nxt_mdio = rd_c[15];
            nxt_sh   = {rd_c[14:0], 1'b0};
          end
        end
        DATA:
        begin
          nxt_cnt = cnt_ff + 6'h01;
          if (rd_op_ff)
          begin
            nxt_mdio = sh_ff[15];
            nxt_sh   = {sh_ff[14:0], 1'b0};
          end
          else
            nxt_sh = {sh_ff[14:0], nxt_mdio_lv};
          if (cnt_ff == 6'h0f)
          begin
            // release the line once the master has taken the last bit
            nxt_oe_n = 1'b1;
            nxt_mdio = 1'b1;
            nxt_cnt  = 6'h00;
            nxt_st   = PRE;
            wr_c     = hit_ff && !rd_op_ff;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_ff    <= PRE;
      cnt_ff   <= 6'h00;
      sh_ff    <= 16'h0000;
      rd_op_ff <= 1'b0;
      hit_ff   <= 1'b0;
      regad_ff <= 5'h00;
      mdio_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
    end
    else
    begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      rd_op_ff <= nxt_rd_op;
      hit_ff   <= nxt_hit;
      regad_ff <= nxt_regad;
      mdio_ff  <= nxt_mdio;
      oe_n_ff  <= nxt_oe_n;
    end
  end

  assign mdio_o      = mdio_ff;
  assign mdio_oe_n_o = oe_n_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  id_low_oui_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    regad_ff == phy_regs_pkg::ID_LO_OFS |-> rd_c[15:10] == phy_regs_pkg::OUI_LOW)
    else $error("identifier organisation bits wrong");
  id_low_model_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    regad_ff == phy_regs_pkg::ID_LO_OFS |-> rd_c[9:4] == phy_regs_pkg::MODEL_NUM)
    else $error("model number wrong");
  id_low_rev_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    regad_ff == phy_regs_pkg::ID_LO_OFS |-> rd_c[3:0] == phy_regs_pkg::REVISION)
    else $error("revision number wrong");
  adv_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(wr_c && regad_ff == phy_regs_pkg::ADV_OFS) |=> $stable(adv_ff))
    else $error("advertisement changed without a write");
  adv_follow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_c && regad_ff == phy_regs_pkg::ADV_OFS
    |=> adv_word_o[15:5] == ($past(wr_data_c[15:5]) & phy_regs_pkg::ADV_WR_MASK[15:5]))
    else $error("advertised word does not follow register");
  adv_selector_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    adv_word_o[4:0] == phy_regs_pkg::ADV_SELECTOR)
    else $error("selector field not 00001");
  partner_ack_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    partner_word_valid_i |=> partner_ff[phy_regs_pkg::PARTNER_ACK_BIT]
                             && partner_ff[13] == $past(partner_word_i[13]))
    else $error("partner word not captured");
  partner_clear_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    an_restart_o && !partner_word_valid_i |=> partner_ff == 16'h0000)
    else $error("partner register not cleared on restart");
  restart_pulse_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    an_restart_o |=> !an_restart_o ##0 an_enable_o)
    else $error("restart not a single pulse");
  stat_done_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    regad_ff == phy_regs_pkg::STAT_OFS |-> rd_c[5] == an_complete_i)
    else $error("completion bit wrong");

endmodule
`default_nettype wire

// file: tb/mdio_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_master_model
(
  // clock
  input  wire logic clock_i,
  // device side of the management pin
  input  wire logic dev_data_i,
  input  wire logic dev_oe_n_i,
  // management clock and resolved data line
  output var  logic mdc_o,
  output var  logic line_o
);
  logic drv_en;
  logic drv_val;
  logic drove;

  initial
  begin
    mdc_o = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
    drove = 1'b0;
  end

  // a released line is pulled up on the board
  always_comb line_o = !dev_oe_n_i ? dev_data_i : (drv_en ? drv_val : 1'b1);

  always @(posedge clock_i)
    if (!dev_oe_n_i) drove <= 1'b1;

  // 12 clocks low and high keeps mdc well inside the device's sync limits
  task automatic shift_bit(input logic b, output logic s);
    drv_val = b;
    mdc_o = 1'b0;
    repeat (12) @(posedge clock_i);
    #1;
    s = line_o;
    mdc_o = 1'b1;
    repeat (12) @(posedge clock_i);
    #1;
  endtask

  task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffffffff, 2'b01, (wr ? 2'b01 : 2'b10), phy, ra, 2'b10, wd};
    drove = 1'b0;
    drv_en = 1'b1;
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      if (!wr && i == 17) drv_en = 1'b0;
      shift_bit(bits[i], s);
      if (i < 16) rd[i] = s;
    end
    drv_en = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb/autoneg_ability_id_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_id_registers_test;
  logic        clock_i;
  logic        sys_rst_i;
  logic        mdc;
  logic        line;
  logic        mdio_o;
  logic        mdio_oe_n_o;
  logic [15:0] partner_word;
  logic        partner_word_valid;
  logic        an_complete;
  logic [15:0] adv_word;
  logic        an_restart;
  logic        an_enable;
  int          fails;
  int          n_compared;
  int          cycles;
  int          restarts;

  autoneg_ability_id_registers u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .partner_word_i(partner_word),
    .partner_word_valid_i(partner_word_valid), .an_complete_i(an_complete),
    .adv_word_o(adv_word), .an_restart_o(an_restart), .an_enable_o(an_enable));

  mdio_master_model u_mdc (
    .clock_i(clock_i), .dev_data_i(mdio_o), .dev_oe_n_i(mdio_oe_n_o),
    .mdc_o(mdc), .line_o(line));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (an_restart === 1'b1) restarts++;
    if (cycles == 90000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    u_mdc.frame(1'b1, phy_regs_pkg::PHY_ADDR, ra, d, unused);
    check({15'h0000, u_mdc.drove}, 16'h0000, "device quiet on write");
  endtask

  task automatic rd_check(input logic [4:0] ra, input logic [15:0] exp, input string what);
    logic [15:0] got;
    u_mdc.frame(1'b0, phy_regs_pkg::PHY_ADDR, ra, 16'h0000, got);
    check(got, exp, what);
    check({15'h0000, u_mdc.drove}, 16'h0001, "device drove read");
  endtask

  task automatic send_word(input logic [15:0] w);
    partner_word = w;
    partner_word_valid = 1'b1;
    @(posedge clock_i);
    #1;
    partner_word_valid = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_defaults();
    logic [15:0] got;
    check(adv_word, 16'h05e1, "adv out");
    rd_check(phy_regs_pkg::ID_HI_OFS, phy_regs_pkg::ID_HI_VAL, "id high");
    u_mdc.frame(1'b1, phy_regs_pkg::PHY_ADDR + 5'h01, phy_regs_pkg::ADV_OFS, 16'h0000, got);
    check(adv_word, 16'h05e1, "other address write");
    u_mdc.frame(1'b0, phy_regs_pkg::PHY_ADDR + 5'h01, phy_regs_pkg::ADV_OFS, 16'h0000, got);
    check(got, 16'hffff, "other address read");
    rd_check(phy_regs_pkg::ID_LO_OFS, {phy_regs_pkg::OUI_LOW, phy_regs_pkg::MODEL_NUM,
             phy_regs_pkg::REVISION}, "id low");
    wr(phy_regs_pkg::ID_LO_OFS, 16'h0000);
    rd_check(phy_regs_pkg::ID_LO_OFS, {phy_regs_pkg::OUI_LOW, phy_regs_pkg::MODEL_NUM,
             phy_regs_pkg::REVISION}, "id low kept");
    rd_check(phy_regs_pkg::ADV_OFS, 16'h05e1, "adv reset");
    wr(phy_regs_pkg::PARTNER_OFS, 16'hffff);
    rd_check(phy_regs_pkg::PARTNER_OFS, 16'h0000, "partner reset");
    $display("test defaults done");
  endtask

  // bit 9 is never set by software, the transceiver lacks that mode
  task automatic test_adv_bits();
    int          bl[7] = '{15, 13, 10, 8, 7, 6, 5};
    logic [15:0] got;
    logic [15:0] exp;
    foreach (bl[k])
    begin
      exp = (16'h0001 << bl[k]) | 16'h0001;
      wr(phy_regs_pkg::ADV_OFS, (16'h0001 << bl[k]) | 16'h581e);
      check(adv_word, exp, "adv out");
      u_mdc.frame(1'b0, phy_regs_pkg::PHY_ADDR, phy_regs_pkg::ADV_OFS, 16'h0000, got);
      check(got & 16'ha7ff, exp, "adv read");
    end
    $display("test adv bits done");
  endtask

  task automatic test_partner();
    int cnt;
    send_word(16'hffff);
    rd_check(phy_regs_pkg::PARTNER_OFS, 16'he7ff, "partner all");
    send_word(16'h2421);
    rd_check(phy_regs_pkg::PARTNER_OFS, 16'h6421, "partner mix");
    cnt = restarts;
    wr(phy_regs_pkg::CTRL_OFS, 16'h1200);
    check(16'(restarts - cnt), 16'h0001, "restart pulse");
    rd_check(phy_regs_pkg::PARTNER_OFS, 16'h0000, "partner cleared");
    rd_check(phy_regs_pkg::CTRL_OFS, 16'h1000, "restart reads 0");
    wr(phy_regs_pkg::CTRL_OFS, 16'h0200);
    check({an_enable, 15'(restarts - cnt)}, 16'h0001, "no restart off");
    wr(phy_regs_pkg::CTRL_OFS, 16'h1000);
    $display("test partner done");
  endtask

  task automatic test_status_and_reset();
    an_complete = 1'b1;
    rd_check(phy_regs_pkg::STAT_OFS, 16'h0020, "done set");
    an_complete = 1'b0;
    rd_check(phy_regs_pkg::STAT_OFS, 16'h0000, "done clear");
    wr(phy_regs_pkg::ADV_OFS, 16'ha400);
    send_word(16'hffff);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    check(adv_word, 16'h05e1, "adv out reset");
    rd_check(phy_regs_pkg::ADV_OFS, 16'h05e1, "adv reread");
    rd_check(phy_regs_pkg::PARTNER_OFS, 16'h0000, "partner reread");
    $display("test status and reset done");
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    partner_word = 16'h0000;
    partner_word_valid = 1'b0;
    an_complete = 1'b0;
    repeat (16) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    test_defaults();
    test_adv_bits();
    test_partner();
    test_status_and_reset();
    finish_test();
  end
endmodule
`default_nettype wire
